/* File: pkg/mpto_pkg.sv */
`default_nettype none
package mpto_pkg;
    // Clock and pulse rates
    localparam int CLK_PERIOD_NS = 5;
    localparam int NS_PER_S = 1000000000;
    localparam int CLK_HZ = NS_PER_S / CLK_PERIOD_NS;
    localparam int FS_RATE_PPS = 1440;
    localparam int MAX_RATE_PPS = 2400;
    // Full-scale period is a longest time, saturation period a least time
    localparam int PERIOD_FS_CYC = CLK_HZ / FS_RATE_PPS;
    localparam int PERIOD_SAT_CYC = (CLK_HZ + MAX_RATE_PPS - 1) / MAX_RATE_PPS;
    // Calibration width unit
    localparam int CAL_UNIT_NS = 1000;
    localparam int CAL_UNIT_CYC = CAL_UNIT_NS / CLK_PERIOD_NS;

    // Widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int VAL_W = 16;
    localparam int SRC_W = 8;
    localparam int PER_W = 34;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_SRC = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FREF = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CREF = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CAL = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h5;

    // Monitor source codes
    localparam logic [SRC_W-1:0] SRC_FREQ = 8'h01;
    localparam logic [SRC_W-1:0] SRC_CURR = 8'h02;
    localparam logic [SRC_W-1:0] SRC_REF = 8'h15;

    // Reset values and limits (frequency 0.01 Hz, current 0.01 A)
    localparam logic [SRC_W-1:0] SRC_RESET = 8'h01;
    localparam logic [VAL_W-1:0] FREF_RESET = 16'h1770;
    localparam logic [VAL_W-1:0] FREF_MAX = 16'h9C40;
    localparam logic [VAL_W-1:0] CREF_RESET = 16'h0BB8;
    localparam logic [VAL_W-1:0] CREF_MAX = 16'hC350;
    localparam logic [VAL_W-1:0] CAL_RESET = 16'h0064;

    // Status bit positions
    localparam int ST_RUN = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_SAT = 3;

    typedef enum logic [1:0] {
        MPTO_IDLE = 2'b00,
        MPTO_CALC = 2'b01
    } mpto_state_e;
endpackage
`default_nettype wire

/* File: rtl/mpto_divider.sv */
`timescale 1ns/10ps
`default_nettype none
// Restoring divider, one quotient bit per clock
module mpto_divider #(
    parameter int NUM_W = 34,
    parameter int DEN_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic [NUM_W-1:0] num,
    input wire logic [DEN_W-1:0] den,
    // Answer
    output logic done,
    output logic [NUM_W-1:0] quo
);
    localparam int CNT_W = $clog2(NUM_W + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(NUM_W);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);

    logic [DEN_W-1:0] rem_q;
    logic [DEN_W-1:0] rem_d;
    logic [DEN_W-1:0] den_q;
    logic [NUM_W-1:0] dvd_q;
    logic [CNT_W-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic [DEN_W:0] shifted;
    logic take;

    always_comb begin
        shifted = {rem_q, dvd_q[NUM_W-1]};
        take = shifted >= {1'b0, den_q};
        rem_d = take ? DEN_W'(shifted - {1'b0, den_q}) : DEN_W'(shifted);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem_q <= '0;
            den_q <= '0;
            dvd_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            rem_q <= '0;
            den_q <= den;
            dvd_q <= num;
            cnt_q <= CNT_LOAD;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q) begin
            rem_q <= rem_d;
            dvd_q <= {dvd_q[NUM_W-2:0], take};
            cnt_q <= cnt_q - CNT_LAST;
            busy_q <= cnt_q != CNT_LAST;
            done_q <= cnt_q == CNT_LAST;
        end else begin
            done_q <= 1'b0;
        end
    end

    assign done = done_q;
    assign quo = dvd_q;
endmodule // mpto_divider
`default_nettype wire

/* File: rtl/mpto_top.sv */
`timescale 1ns/10ps
`default_nettype none
module mpto_top #(
    parameter logic [mpto_pkg::PER_W-1:0] PERIOD_FS_CYC =
        mpto_pkg::PER_W'(mpto_pkg::PERIOD_FS_CYC),
    parameter logic [mpto_pkg::PER_W-1:0] PERIOD_SAT_CYC =
        mpto_pkg::PER_W'(mpto_pkg::PERIOD_SAT_CYC),
    parameter logic [mpto_pkg::VAL_W-1:0] CREF_RESET = mpto_pkg::CREF_RESET
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [mpto_pkg::ADDR_W-1:0] addr,
    input wire logic [mpto_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [mpto_pkg::DATA_W-1:0] rdata,
    // Monitor quantities from the drive core
    input wire logic [mpto_pkg::VAL_W-1:0] output_frequency,
    input wire logic [mpto_pkg::VAL_W-1:0] output_current,
    input wire logic running,
    input wire logic parameter_write_restriction,
    // Pulse terminal
    output logic pulse_monitor_output
);
    localparam int PW = mpto_pkg::PER_W;
    localparam int VW = mpto_pkg::VAL_W;
    localparam logic [PW-1:0] PER_ONE = PW'(1);
    localparam logic [PW-1:0] CAL_UNIT = PW'(mpto_pkg::CAL_UNIT_CYC);
    localparam int SW = mpto_pkg::SRC_W;
    localparam int DW = mpto_pkg::DATA_W;
    localparam int KEY_W = SW + 2 * VW;
    // Divider answers after one load clock plus one clock per quotient bit
    localparam int DIV_LAT = PW + 1;

    function automatic logic hit(input logic [mpto_pkg::ADDR_W-1:0] a,
                                 input logic [mpto_pkg::ADDR_W-1:0] reg_addr);
        hit = a == reg_addr;
    endfunction

    // Current source picks the current value and reference
    function automatic logic is_curr(input logic [SW-1:0] src);
        is_curr = src == mpto_pkg::SRC_CURR;
    endfunction

    // Reference code shows full scale without a running drive
    function automatic logic needs_run(input logic [SW-1:0] src);
        needs_run = src != mpto_pkg::SRC_REF;
    endfunction

    function automatic logic is_known(input logic [DW-1:0] code);
        is_known = code == DW'(mpto_pkg::SRC_FREQ) || code == DW'(mpto_pkg::SRC_CURR) ||
            code == DW'(mpto_pkg::SRC_REF);
    endfunction

    function automatic logic [PW-1:0] high_of(input logic [PW-1:0] per,
                                              input logic [PW-1:0] width);
        if (per == '0) begin
            high_of = '0;
        end else if (width >= per) begin
            high_of = per - PER_ONE;
        end else begin
            high_of = width;
        end
    endfunction

    logic [mpto_pkg::SRC_W-1:0] src_q;
    logic [VW-1:0] fref_q;
    logic [VW-1:0] cref_q;
    logic [VW-1:0] cal_q;
    logic refused_q;
    logic [mpto_pkg::DATA_W-1:0] rdata_q;
    logic sat_q;
    logic pulse_q;
    logic [PW-1:0] per_new_q;
    logic [PW-1:0] per_act_q;
    logic [PW-1:0] hi_act_q;
    logic [PW-1:0] phase_q;
    logic [KEY_W-1:0] key_q;
    mpto_pkg::mpto_state_e state_q;

    logic [VW-1:0] sel_val;
    logic [VW-1:0] sel_ref;
    logic [KEY_W-1:0] key_now;
    logic changed;
    logic div_start;
    logic div_done;
    logic [PW-1:0] div_num;
    logic [PW-1:0] div_quo;
    logic [PW-1:0] per_lim;
    logic [PW-1:0] cal_cyc;
    logic [PW-1:0] hi_next;
    logic wrap;
    logic pulse_d;
    logic restricted;
    logic wr_src_ok;
    logic wr_fref_ok;
    logic wr_cref_ok;
    logic wr_cal_ok;
    logic wr_refused;
    logic [DW-1:0] rd_mux;

    // Write qualification
    always_comb begin
        restricted = parameter_write_restriction && running;
        // Source choice is a general setting and obeys the restriction
        wr_src_ok = is_known(wdata) && !restricted;
        wr_fref_ok = wdata <= DW'(mpto_pkg::FREF_MAX);
        wr_cref_ok = wdata <= DW'(mpto_pkg::CREF_MAX);
        // Calibration while stopped only if the source needs no drive
        wr_cal_ok = wdata[DW-1:VW] == '0 && (running || !needs_run(src_q));
        wr_refused = wr && ((hit(addr, mpto_pkg::ADDR_SRC) && !wr_src_ok) ||
            (hit(addr, mpto_pkg::ADDR_FREF) && !wr_fref_ok) ||
            (hit(addr, mpto_pkg::ADDR_CREF) && !wr_cref_ok) ||
            (hit(addr, mpto_pkg::ADDR_CAL) && !wr_cal_ok));
    end

    // Settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_q <= mpto_pkg::SRC_RESET;
            fref_q <= mpto_pkg::FREF_RESET;
            cref_q <= CREF_RESET;
            cal_q <= mpto_pkg::CAL_RESET;
        end else if (wr) begin
            if (hit(addr, mpto_pkg::ADDR_SRC) && wr_src_ok) begin
                src_q <= wdata[SW-1:0];
            end
            if (hit(addr, mpto_pkg::ADDR_FREF) && wr_fref_ok) begin
                fref_q <= wdata[VW-1:0];
            end
            if (hit(addr, mpto_pkg::ADDR_CREF) && wr_cref_ok) begin
                cref_q <= wdata[VW-1:0];
            end
            if (hit(addr, mpto_pkg::ADDR_CAL) && wr_cal_ok) begin
                cal_q <= wdata[VW-1:0];
            end
        end
    end

    // Refused write flag, cleared by reading status; a new refusal wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (wr_refused) begin
            refused_q <= 1'b1;
        end else if (rd && hit(addr, mpto_pkg::ADDR_STATUS)) begin
            refused_q <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_mux = '0;
        case (addr)
            mpto_pkg::ADDR_SRC: begin
                rd_mux = DW'(src_q);
            end
            mpto_pkg::ADDR_FREF: begin
                rd_mux = DW'(fref_q);
            end
            mpto_pkg::ADDR_CREF: begin
                rd_mux = DW'(cref_q);
            end
            mpto_pkg::ADDR_CAL: begin
                rd_mux = DW'(cal_q);
            end
            mpto_pkg::ADDR_STATUS: begin
                rd_mux[mpto_pkg::ST_RUN] = running;
                rd_mux[mpto_pkg::ST_BUSY] = state_q != mpto_pkg::MPTO_IDLE;
                rd_mux[mpto_pkg::ST_REFUSED] = refused_q;
                rd_mux[mpto_pkg::ST_SAT] = sat_q;
            end
            mpto_pkg::ADDR_PERIOD: begin
                rd_mux = DW'(per_act_q);
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Read data stand for the one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd ? rd_mux : '0;
        end
    end

    // Monitor value and its full-scale reference
    always_comb begin
        sel_val = is_curr(src_q) ? output_current : output_frequency;
        sel_ref = is_curr(src_q) ? cref_q : fref_q;
        key_now = {src_q, sel_val, sel_ref};
        changed = key_now != key_q;
        // Period is full-scale period times reference over value
        div_num = PERIOD_FS_CYC * PW'(sel_ref);
        div_start = state_q == mpto_pkg::MPTO_IDLE && changed &&
            src_q != mpto_pkg::SRC_REF && sel_val != '0;
        // Never shorter than the fastest allowed period
        per_lim = div_quo < PERIOD_SAT_CYC ? PERIOD_SAT_CYC : div_quo;
    end

    // Period divider
    mpto_divider #(
        .NUM_W(PW),
        .DEN_W(VW)
    ) i_mpto_divider (
        .clk(clk),
        .rst(rst),
        .start(div_start),
        .num(div_num),
        .den(sel_val),
        .done(div_done),
        .quo(div_quo)
    );

    // Recompute the period whenever source, value or reference moves
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= mpto_pkg::MPTO_IDLE;
            key_q <= '0;
            per_new_q <= '0;
            sat_q <= 1'b0;
        end else begin
            unique case (state_q)
                mpto_pkg::MPTO_IDLE: begin
                    if (changed) begin
                        key_q <= key_now;
                        if (src_q == mpto_pkg::SRC_REF) begin
                            per_new_q <= PERIOD_FS_CYC;
                            sat_q <= 1'b0;
                        end else if (sel_val == '0) begin
                            per_new_q <= '0;
                            sat_q <= 1'b0;
                        end else begin
                            state_q <= mpto_pkg::MPTO_CALC;
                        end
                    end
                end
                mpto_pkg::MPTO_CALC: begin
                    if (div_done) begin
                        per_new_q <= per_lim;
                        sat_q <= div_quo < PERIOD_SAT_CYC;
                        state_q <= mpto_pkg::MPTO_IDLE;
                    end
                end
                default: begin
                    state_q <= mpto_pkg::MPTO_IDLE;
                end
            endcase
        end
    end

    // New period and high time take effect only at a wrap
    always_comb begin
        cal_cyc = PW'(cal_q) * CAL_UNIT;
        wrap = per_act_q == '0 || phase_q == per_act_q - PER_ONE;
        hi_next = high_of(per_new_q, cal_cyc);
        pulse_d = wrap ? hi_next != '0 : (phase_q + PER_ONE) < hi_act_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            per_act_q <= '0;
            hi_act_q <= '0;
            phase_q <= '0;
        end else if (wrap) begin
            per_act_q <= per_new_q;
            hi_act_q <= hi_next;
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + PER_ONE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
        end
    end

    assign rdata = rdata_q;
    assign pulse_monitor_output = pulse_q;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_div_start;
        state_q == mpto_pkg::MPTO_IDLE && div_start;
    endsequence
    sequence s_zero_idle;
        per_new_q == '0 && per_act_q == '0;
    endsequence
    chk_div_latency: assert property (s_div_start |-> ##[DIV_LAT:DIV_LAT] div_done)
        else $error("Divider answer not on time");
    chk_rate_cap: assert property (per_act_q != '0 |-> per_act_q >= PERIOD_SAT_CYC)
        else $error("Pulse period below the saturation period");
    chk_ref_period: assert property ((src_q == mpto_pkg::SRC_REF && !changed &&
        state_q == mpto_pkg::MPTO_IDLE) |-> per_new_q == PERIOD_FS_CYC)
        else $error("Reference code period is not full scale");
    chk_zero_quiet: assert property (s_zero_idle |=> !pulse_q)
        else $error("Pulse seen with a zero monitor value");
    chk_cal_refused: assert property ((wr && hit(addr, mpto_pkg::ADDR_CAL) && !running &&
        needs_run(src_q)) |=> $stable(cal_q))
        else $error("Calibration taken while stopped");
    chk_fref_range: assert property (fref_q <= mpto_pkg::FREF_MAX)
        else $error("Frequency reference out of range");
    chk_cref_range: assert property (cref_q <= mpto_pkg::CREF_MAX)
        else $error("Current reference out of range");
    chk_rdata_idle: assert property (!rd |=> rdata == '0)
        else $error("Read data outside its cycle");
endmodule // mpto_top
`default_nettype wire

/* File: tb/mpto_pulse_meter.sv */
`timescale 1ns/10ps
`default_nettype none
// Counter at the pulse terminal: period and high time in clocks
module mpto_pulse_meter (
    // Clock and pulse
    input wire logic clk,
    input wire logic pin,
    // Measurements
    output int edges = 0,
    output int per = 0,
    output int hi = 0
);
    int run_q = 0;
    int hi_q = 0;
    logic last_q = 1'b0;
    always @(posedge clk) begin
        last_q <= pin;
        run_q <= (pin && !last_q) ? 1 : run_q + 1;
        hi_q <= (pin && !last_q) ? 1 : hi_q + 1;
        if (pin && !last_q) begin
            edges <= edges + 1;
            per <= run_q;
        end
        if (!pin && last_q) hi <= hi_q;
    end
endmodule // mpto_pulse_meter
`default_nettype wire

/* File: tb/tb_mpto_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_mpto_top;
    localparam int FS = 600;
    localparam int H = mpto_pkg::CAL_UNIT_CYC;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] fq = '0;
    logic [15:0] cu = '0;
    logic run = 1'b0;
    logic pwr = 1'b0;
    logic pin;
    int edges, per, hi;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    mpto_top #(.PERIOD_FS_CYC(34'(FS)), .PERIOD_SAT_CYC(34'(360))) i_mpto_top (.clk(clk),
        .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .output_frequency(fq), .output_current(cu), .running(run),
        .parameter_write_restriction(pwr), .pulse_monitor_output(pin));
    mpto_pulse_meter i_mpto_pulse_meter (.clk(clk), .pin(pin), .edges(edges), .per(per),
        .hi(hi));
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: saw %0h want %0h", $time, s, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, e);
        @(posedge clk);
    endtask
    task automatic meas(input int p, input int h);
        int e;
        e = edges;
        for (int i = 0; i < 9000 && edges < e + 3; i++) @(posedge clk);
        check(32'(per), 32'(p));
        check(32'(hi), 32'(h));
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(mpto_pkg::ADDR_SRC, 32'(mpto_pkg::SRC_RESET));
        rd_reg(mpto_pkg::ADDR_FREF, 32'(mpto_pkg::FREF_RESET));
        rd_reg(mpto_pkg::ADDR_CAL, 32'(mpto_pkg::CAL_RESET));
        run <= 1'b1;
        pwr <= 1'b1;
        wr_reg(mpto_pkg::ADDR_CAL, 32'h0000_0001);
        rd_reg(mpto_pkg::ADDR_CAL, 32'h0000_0001);
        wr_reg(mpto_pkg::ADDR_FREF, 32'h0000_9C41);
        rd_reg(mpto_pkg::ADDR_FREF, 32'(mpto_pkg::FREF_RESET));
        wr_reg(mpto_pkg::ADDR_CREF, 32'h0000_C351);
        rd_reg(mpto_pkg::ADDR_CREF, 32'(mpto_pkg::CREF_RESET));
        wr_reg(mpto_pkg::ADDR_SRC, 32'(mpto_pkg::SRC_CURR));
        rd_reg(mpto_pkg::ADDR_SRC, 32'(mpto_pkg::SRC_FREQ));
        rd_reg(mpto_pkg::ADDR_STATUS, 32'h0000_0005);
        rd_reg(mpto_pkg::ADDR_STATUS, 32'h0000_0001);
        fq <= mpto_pkg::FREF_RESET;
        meas(FS, H);
        fq <= 16'h0BB8;
        meas(2 * FS, H);
        fq <= 16'h2EE0;
        meas(360, H);
        rd_reg(mpto_pkg::ADDR_STATUS, 32'h0000_0009);
        wr_reg(mpto_pkg::ADDR_FREF, 32'h0000_2EE0);
        meas(FS, H);
        wr_reg(mpto_pkg::ADDR_FREF, 32'(mpto_pkg::FREF_RESET));
        fq <= mpto_pkg::FREF_RESET;
        wr_reg(mpto_pkg::ADDR_CAL, 32'h0000_0002);
        meas(FS, 2 * H);
        pwr <= 1'b0;
        wr_reg(mpto_pkg::ADDR_SRC, 32'(mpto_pkg::SRC_CURR));
        cu <= mpto_pkg::CREF_RESET;
        meas(FS, 2 * H);
        run <= 1'b0;
        fq <= 16'h0000;
        cu <= 16'h0000;
        wr_reg(mpto_pkg::ADDR_SRC, 32'(mpto_pkg::SRC_REF));
        meas(FS, 2 * H);
        wr_reg(mpto_pkg::ADDR_SRC, 32'(mpto_pkg::SRC_FREQ));
        repeat (2000) @(posedge clk);
        rd_reg(mpto_pkg::ADDR_PERIOD, 32'h0000_0000);
        cyc <= 0;
        begin : quiet
            int e;
            e = edges;
            repeat (3 * FS) @(posedge clk);
            check(32'(edges), 32'(e));
        end
        wr_reg(mpto_pkg::ADDR_CAL, 32'h0000_0005);
        rd_reg(mpto_pkg::ADDR_CAL, 32'h0000_0002);
        rd_reg(mpto_pkg::ADDR_STATUS, 32'h0000_0004);
        end_of_test();
    end
endmodule // tb_mpto_top
`default_nettype wire
